// [hw/mac_ctl_pkg.sv]
/*
  Shared constants and carriers for the MAC pause, error-flag and station
  address slice. Assumes a 32-bit APB register bus and a 100 MHz clock.
*/
package mac_ctl_pkg;
  // Byte offsets of the registers.
  localparam logic [11:0] OFS_PAUSE_CTL = 12'h010c;
  localparam logic [11:0] OFS_SEED = 12'h0110;
  localparam logic [11:0] OFS_ERR = 12'h0114;
  localparam logic [11:0] OFS_ADDR_HI = 12'h0118;
  localparam logic [11:0] OFS_ADDR_LO = 12'h011c;
  // Field positions in pause_control.
  localparam int B_SEND_NOW = 31;
  localparam int B_AUTO_EN = 30;
  localparam int B_HONOR_EN = 29;
  localparam int B_PASS = 28;
  // Error flags live in bits 9..2 of frame_error_flags.
  localparam int ERR_LSB = 2;
  localparam int ERR_N = 8;
  // Reset values.
  localparam logic [15:0] SEED_RST = 16'h9876;
  localparam logic [15:0] ADDR_HI_RST = 16'hffff;
  localparam logic [31:0] ADDR_LO_RST = 32'hffff_ffff;
  // Receive FIFO fill is compared in units of 512 bytes.
  localparam int FILL_SHIFT = 9;
  // Pause quanta are 512 bit times; at one byte per clock that is 64.
  localparam int QUANTUM_BITS = 512;
  localparam int BITS_PER_CLK = 8;
  localparam int SLOT_CLKS = QUANTUM_BITS / BITS_PER_CLK;
  localparam int PCNT_W = 23;
  // MAC control frame constants.
  localparam logic [47:0] PAUSE_DA = 48'h0180_c200_0001;
  localparam logic [15:0] CTL_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OP = 16'h0001;

  // Header of a generated pause frame, handed to the transmit path.
  typedef struct packed {
    logic [47:0] da;
    logic [47:0] sa;
    logic [15:0] etype;
    logic [15:0] opcode;
    logic [15:0] quanta;
    logic addFcs;
  } pause_frame_t;

  // Watermarks from the receive FIFO threshold configuration.
  typedef struct packed {
    logic [7:0] on;
    logic [7:0] off;
  } pause_thresh_t;

  // Whole state of the block.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sendNow;
    logic autoEn;
    logic honorEn;
    logic passPause;
    logic [15:0] quanta;
    logic [15:0] seed;
    logic [15:0] lfsr;
    logic [ERR_N-1:0] errFlags;
    logic [15:0] addrHi;
    logic [31:0] addrLo;
    logic loaded;
    logic srcValid;
    logic [47:0] srcAddr;
    logic autoHigh;
    logic onPend;
    logic offPend;
    logic txReq;
    logic reqForced;
    pause_frame_t txFrame;
    logic [PCNT_W-1:0] pauseCnt;
    logic txHalt;
    logic decodeEn;
  } state_t;
endpackage : mac_ctl_pkg

// [hw/mac_pause_error_station_addr.sv]
/*
  Pause flow control, back-off seed, sticky error flags and station
  address of the MAC, with an APB slave for the registers.
  Assumes the receive path reports pause frames and errors as one-cycle
  pulses and the transmit path acknowledges a pause frame with a pulse.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

// Function
// - Halt transmit for quanta times slot time
// - Honour disabled: no decoding, no halt
// - Send-now sends one frame, then self-clears
// - Fill over on-threshold sends pause quanta
// - Fill under off-threshold then sends zero
// - Flow control only in full duplex
// - Pass bit forwards or sinks pause frames
// - Programmed quanta fills pause time field
// - Back-off LFSR seeded, seed resets 9876h
// - Sticky flags for rx, crc, size errors
// - Overlong truncated frame sets bit five
// - Sixteen collisions abort sets bit four
// - Misalignment bit three, starvation bit two
// - 48-bit address split, first octet low
// - Address for match, wake, pause frames
// - Address unused in general receive filter
// - Reset loads EEPROM, else OTP, else ones
// - USB reset restores loaded address, else sets low word to ones
module mac_pause_error_station_addr
  import mac_ctl_pkg::*;
#(
  parameter int FILL_W = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link mode and receive side.
  input wire logic fullDuplex,
  input wire logic rxPauseValid,
  input wire logic [15:0] rxPauseQuanta,
  input wire logic [FILL_W-1:0] rxFifoFill,
  input wire pause_thresh_t pauseThresholdCfg,
  input wire logic [ERR_N-1:0] errEvt,
  // Transmit side.
  input wire logic txPauseDone,
  output logic txPauseReq,
  output pause_frame_t txPauseFrame,
  output logic txHalt,
  output logic ctlDecodeEn,
  output logic passPauseFrames,
  output logic [15:0] backoffRand,
  // Address sources and USB reset.
  input wire logic eepromPresent,
  input wire logic [47:0] eepromAddr,
  input wire logic otpConfigured,
  input wire logic [47:0] otpAddr,
  input wire logic usbReset,
  output logic [47:0] stationAddr
);

  // Reset image of the state.
  localparam state_t STATE_RST = '{
    seed: SEED_RST, lfsr: SEED_RST, addrHi: ADDR_HI_RST,
    addrLo: ADDR_LO_RST, default: '0};

  state_t s_r; // Registered state.
  state_t s_nxt; // Next state.
  logic setup; // APB setup cycle.
  logic wrEn; // Write completes at this edge.
  logic fd; // Full duplex qualifies every flow control action.
  logic [FILL_W-FILL_SHIFT-1:0] fillBlk; // Fill in 512-byte units.
  logic lfsrFb; // LFSR feedback bit.

  assign setup = psel && !penable;
  assign wrEn = psel && penable && s_r.pready && pwrite;
  assign fd = fullDuplex;
  assign fillBlk = rxFifoFill[FILL_W-1:FILL_SHIFT];
  assign lfsrFb = s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10];

  // Next-state logic for registers, pause engine and address.
  always_comb begin
    s_nxt = s_r;
    // Zero wait state: answer in the first access cycle.
    s_nxt.pready = setup;
    s_nxt.pslverr = 1'b0;
    if (setup) begin
      s_nxt.prdata = '0;
      unique case (paddr)
        OFS_PAUSE_CTL: begin
          s_nxt.prdata[B_SEND_NOW] = s_r.sendNow;
          s_nxt.prdata[B_AUTO_EN] = s_r.autoEn;
          s_nxt.prdata[B_HONOR_EN] = s_r.honorEn;
          s_nxt.prdata[B_PASS] = s_r.passPause;
          s_nxt.prdata[15:0] = s_r.quanta;
        end
        OFS_SEED: s_nxt.prdata[15:0] = s_r.seed;
        OFS_ERR: s_nxt.prdata[ERR_LSB+:ERR_N] = s_r.errFlags;
        OFS_ADDR_HI: s_nxt.prdata[15:0] = s_r.addrHi;
        OFS_ADDR_LO: s_nxt.prdata = s_r.addrLo;
        default: s_nxt.pslverr = 1'b1;
      endcase
    end

    // Error flags: events set, a one written clears, and set wins.
    s_nxt.errFlags = s_r.errFlags;
    if (wrEn && paddr == OFS_ERR) begin
      s_nxt.errFlags = s_r.errFlags & ~pwdata[ERR_LSB+:ERR_N];
    end
    s_nxt.errFlags = s_nxt.errFlags | errEvt;

    // The LFSR free-runs; a seed write reloads it at once.
    s_nxt.lfsr = (s_r.lfsr == '0) ? s_r.seed
                 : {s_r.lfsr[14:0], lfsrFb};

    // Register writes.
    if (wrEn) begin
      unique case (paddr)
        OFS_PAUSE_CTL: begin
          // Writing zero to send-now never cancels a pending frame.
          s_nxt.sendNow = s_r.sendNow | pwdata[B_SEND_NOW];
          s_nxt.autoEn = pwdata[B_AUTO_EN];
          s_nxt.honorEn = pwdata[B_HONOR_EN];
          s_nxt.passPause = pwdata[B_PASS];
          s_nxt.quanta = pwdata[15:0];
        end
        OFS_SEED: begin
          s_nxt.seed = pwdata[15:0];
          s_nxt.lfsr = pwdata[15:0];
        end
        OFS_ADDR_HI: s_nxt.addrHi = pwdata[15:0];
        OFS_ADDR_LO: s_nxt.addrLo = pwdata;
        default: ;
      endcase
    end

    // Station address source is caught once, right after reset.
    if (!s_r.loaded) begin
      s_nxt.loaded = 1'b1;
      if (eepromPresent) begin
        s_nxt.srcValid = 1'b1;
        s_nxt.srcAddr = eepromAddr;
      end else if (otpConfigured) begin
        s_nxt.srcValid = 1'b1;
        s_nxt.srcAddr = otpAddr;
      end
      // With neither source the all-ones reset image stays.
      if (eepromPresent || otpConfigured) begin
        s_nxt.addrHi = s_nxt.srcAddr[47:32];
        s_nxt.addrLo = s_nxt.srcAddr[31:0];
      end
    end else if (usbReset) begin
      // A USB reset overrides a same-cycle register write, but with no source an address-high write stays.
      if (s_r.srcValid) begin
        s_nxt.addrHi = s_r.srcAddr[47:32];
        s_nxt.addrLo = s_r.srcAddr[31:0];
      end else begin
        s_nxt.addrLo = ADDR_LO_RST;
      end
    end

    // Watermark tracking; an edge queues a frame, and a later edge replaces one still pending.
    if (s_r.autoEn && fd) begin
      if (!s_r.autoHigh && fillBlk >= pauseThresholdCfg.on) begin
        s_nxt.autoHigh = 1'b1;
        s_nxt.onPend = 1'b1;
        s_nxt.offPend = 1'b0;
      end else if (s_r.autoHigh && fillBlk <= pauseThresholdCfg.off) begin
        s_nxt.autoHigh = 1'b0;
        s_nxt.offPend = 1'b1;
        s_nxt.onPend = 1'b0;
      end
    end else begin
      // Disabling auto pause or leaving full duplex drops the state.
      s_nxt.autoHigh = 1'b0;
      s_nxt.onPend = 1'b0;
      s_nxt.offPend = 1'b0;
    end

    // Transmit request: one frame outstanding; forced goes first.
    if (s_r.txReq) begin
      if (txPauseDone) begin
        s_nxt.txReq = 1'b0;
        if (s_r.reqForced) begin
          // A send-now written in the very cycle the frame leaves is kept.
          // The set wins here; a second request written earlier while the frame is out is cleared with it.
          if (!(wrEn && paddr == OFS_PAUSE_CTL && pwdata[B_SEND_NOW])) begin
            s_nxt.sendNow = 1'b0;
          end
        end
      end
    end else if (fd && (s_r.sendNow || s_nxt.onPend || s_nxt.offPend)) begin
      s_nxt.txReq = 1'b1;
      s_nxt.reqForced = s_r.sendNow;
      s_nxt.txFrame.da = PAUSE_DA;
      // Source in wire order, first octet on top, laid out like the
      // destination, so the transmit path sends both the same way.
      s_nxt.txFrame.sa = {s_nxt.addrLo[7:0], s_nxt.addrLo[15:8],
        s_nxt.addrLo[23:16], s_nxt.addrLo[31:24],
        s_nxt.addrHi[7:0], s_nxt.addrHi[15:8]};
      s_nxt.txFrame.etype = CTL_TYPE;
      s_nxt.txFrame.opcode = PAUSE_OP;
      s_nxt.txFrame.addFcs = 1'b1;
      if (s_r.sendNow || s_nxt.onPend) begin
        s_nxt.txFrame.quanta = s_r.quanta;
      end else begin
        s_nxt.txFrame.quanta = '0;
      end
      if (!s_r.sendNow) begin
        s_nxt.onPend = 1'b0;
        s_nxt.offPend = 1'b0;
      end
    end

    // Received pause: timer of quanta times slot time.
    s_nxt.decodeEn = s_r.honorEn && fd;
    if (s_r.pauseCnt != '0) begin
      s_nxt.pauseCnt = s_r.pauseCnt - 1'b1;
    end
    if (rxPauseValid && s_r.decodeEn) begin
      s_nxt.pauseCnt = PCNT_W'(rxPauseQuanta * SLOT_CLKS);
    end
    if (!fd) begin
      s_nxt.pauseCnt = '0;
    end
    s_nxt.txHalt = s_nxt.pauseCnt != '0;
  end

  // State register.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs, all straight from the state register.
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign txPauseReq = s_r.txReq;
  assign txPauseFrame = s_r.txFrame;
  assign txHalt = s_r.txHalt;
  assign ctlDecodeEn = s_r.decodeEn;
  assign passPauseFrames = s_r.passPause;
  assign backoffRand = s_r.lfsr;
  // Only match, wake and pause logic read this, not the filter.
  assign stationAddr = {s_r.addrHi, s_r.addrLo};

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_halt;
    rxPauseValid && s_r.decodeEn && fullDuplex && rxPauseQuanta != '0
      |=> txHalt && s_r.pauseCnt == $past(rxPauseQuanta) * SLOT_CLKS;
  endproperty
  a_halt: assert property (p_halt) else $error("pause halt wrong");

  property p_nohonor;
    rxPauseValid && !s_r.decodeEn && !txHalt |=> !txHalt;
  endproperty
  a_nohonor: assert property (p_nohonor) else $error("halt w/o honor");

  property p_sendclr;
    txPauseReq && s_r.reqForced && txPauseDone
      && !(wrEn && paddr == OFS_PAUSE_CTL && pwdata[B_SEND_NOW])
      |=> !s_r.sendNow;
  endproperty
  a_sendclr: assert property (p_sendclr) else $error("send not clear");

  property p_auto_on;
    s_r.autoEn && fullDuplex && !s_r.autoHigh
      && fillBlk >= pauseThresholdCfg.on |=> s_r.autoHigh;
  endproperty
  a_auto_on: assert property (p_auto_on) else $error("on missed");

  property p_off_zero;
    $rose(txPauseReq) && !s_r.reqForced && !s_r.autoHigh
      |-> txPauseFrame.quanta == '0;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("off quanta");

  property p_half;
    !fullDuplex |=> !txHalt && !ctlDecodeEn;
  endproperty
  a_half: assert property (p_half) else $error("flow ctl in half");

  property p_pass;
    wrEn && paddr == OFS_PAUSE_CTL |=> passPauseFrames == $past(pwdata[B_PASS]);
  endproperty
  a_pass: assert property (p_pass) else $error("pass bit");

  property p_quanta;
    $rose(txPauseReq) && s_r.reqForced |-> txPauseFrame.quanta == s_r.quanta
      && txPauseFrame.etype == CTL_TYPE && txPauseFrame.addFcs;
  endproperty
  a_quanta: assert property (p_quanta) else $error("frame fields");

  property p_seed;
    wrEn && paddr == OFS_SEED |=> backoffRand == $past(pwdata[15:0]);
  endproperty
  a_seed: assert property (p_seed) else $error("seed load");

  property p_sticky;
    errEvt != '0 |=> (s_r.errFlags & $past(errEvt)) == $past(errEvt);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_usb;
    s_r.loaded && usbReset && !s_r.srcValid |=> s_r.addrLo == ADDR_LO_RST;
  endproperty
  a_usb: assert property (p_usb) else $error("usb reset addr");

  // The request and its header stand untouched until the done pulse.
  property p_req_hold;
    txPauseReq && !txPauseDone |=> txPauseReq && $stable(txPauseFrame);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req drop");

  // First octet on the wire leads the source field, the sixth ends it.
  property p_sa_order;
    $rose(txPauseReq) |-> txPauseFrame.sa[47:40] == s_r.addrLo[7:0]
      && txPauseFrame.sa[7:0] == s_r.addrHi[15:8];
  endproperty
  a_sa_order: assert property (p_sa_order) else $error("sa order");

  // The first edge after reset takes the EEPROM image, else the OTP one.
  property p_load_ee;
    !s_r.loaded && eepromPresent |=> stationAddr == $past(eepromAddr);
  endproperty
  a_load_ee: assert property (p_load_ee) else $error("eeprom load");

  property p_load_otp;
    !s_r.loaded && !eepromPresent && otpConfigured
      |=> stationAddr == $past(otpAddr);
  endproperty
  a_load_otp: assert property (p_load_otp) else $error("otp load");

  // A one written clears a flag unless its event comes in that cycle.
  property p_err_clr;
    wrEn && paddr == OFS_ERR |=> (s_r.errFlags
      & $past(pwdata[ERR_LSB+:ERR_N]) & ~$past(errEvt)) == '0;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("flag kept");

  // With a source, a USB reset brings back the loaded image whole.
  property p_usb_src;
    s_r.loaded && usbReset && s_r.srcValid
      |=> stationAddr == $past(s_r.srcAddr);
  endproperty
  a_usb_src: assert property (p_usb_src) else $error("usb restore");

  c_forced: cover property (s_r.sendNow ##[1:20] txPauseDone);
  c_on_off: cover property (s_r.autoHigh ##[1:200] $fell(s_r.autoHigh));
  c_halt: cover property ($rose(txHalt));
  c_err_clr: cover property (wrEn && paddr == OFS_ERR && s_r.errFlags != '0);

endmodule : mac_pause_error_station_addr

// [verif/pause_tx_partner.sv]
/*
  Transmit path model that sends requested pause frames.
  Assumes the block holds its request until it sees the done pulse.
*/
`timescale 1ns/1ps
module pause_tx_partner (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Request from the block and the chosen answer delay in cycles.
  input wire logic txPauseReq,
  input wire logic [7:0] ackDelay,
  // Frame has gone out.
  output logic txPauseDone
);
  logic [7:0] waitCnt_r; // Cycles spent on the current frame.

  // A delay knob lets the bench answer promptly or slowly.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      waitCnt_r <= 8'h00;
      txPauseDone <= 1'b0;
    end else begin
      txPauseDone <= 1'b0;
      if (txPauseReq && !txPauseDone) begin
        if (waitCnt_r >= ackDelay) begin
          txPauseDone <= 1'b1;
          waitCnt_r <= 8'h00;
        end else begin
          waitCnt_r <= waitCnt_r + 8'h01;
        end
      end
    end
  end
endmodule : pause_tx_partner

// [verif/mac_pause_error_station_addr_tb.sv]
/*
  Self-checking bench for the MAC pause, error and address slice.
  Assumes one-cycle APB answers and the transmit partner model.
*/
`timescale 1ns/1ps
module mac_pause_error_station_addr_tb;
  import mac_ctl_pkg::*;
  logic clock, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic fullDuplex, rxPauseValid, txPauseDone, txPauseReq, txHalt;
  logic ctlDecodeEn, passPauseFrames, usbReset, errBit;
  logic eepromPresent, otpConfigured;
  logic [15:0] rxPauseQuanta, rxFifoFill, backoffRand;
  pause_thresh_t pauseThresholdCfg;
  logic [ERR_N-1:0] errEvt;
  pause_frame_t txPauseFrame;
  logic [47:0] stationAddr, eepromAddr, otpAddr;
  logic [7:0] ackDelay;
  int error_cnt = 0;
  int check_count = 0;

  mac_pause_error_station_addr i_dut (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fullDuplex(fullDuplex), .rxPauseValid(rxPauseValid),
    .rxPauseQuanta(rxPauseQuanta), .rxFifoFill(rxFifoFill),
    .pauseThresholdCfg(pauseThresholdCfg), .errEvt(errEvt),
    .txPauseDone(txPauseDone), .txPauseReq(txPauseReq),
    .txPauseFrame(txPauseFrame), .txHalt(txHalt),
    .ctlDecodeEn(ctlDecodeEn), .passPauseFrames(passPauseFrames),
    .backoffRand(backoffRand), .eepromPresent(eepromPresent),
    .eepromAddr(eepromAddr), .otpConfigured(otpConfigured),
    .otpAddr(otpAddr), .usbReset(usbReset),
    .stationAddr(stationAddr));
  pause_tx_partner i_partner (.clock(clock), .reset(reset),
    .txPauseReq(txPauseReq), .ackDelay(ackDelay),
    .txPauseDone(txPauseDone));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compare one value and count it.
  task automatic check(input string nm, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready", pready, 1'b1);
    rdv = prdata;
    errBit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check("register", {errBit, rdv}, {1'b0, exp});
  endtask : rchk

  // Waits for a pause request and checks the frame it carries.
  task automatic frame_chk(input logic [15:0] q);
    int n;
    n = 0;
    while (txPauseReq !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    check("request", txPauseReq, 1'b1);
    check("quanta", txPauseFrame.quanta, q);
    check("header", {txPauseFrame.da, txPauseFrame.etype,
      txPauseFrame.opcode, txPauseFrame.addFcs},
      {48'h0180_c200_0001, 16'h8808, 16'h0001, 1'b1});
    check("source", txPauseFrame.sa, 48'h6655_4433_2211);
    n = 0;
    while (txPauseReq !== 1'b0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    check("released", txPauseReq, 1'b0);
  endtask : frame_chk

  task automatic t_reset;
    rchk(OFS_PAUSE_CTL, 32'h0000_0000);
    rchk(OFS_SEED, 32'h0000_9876);
    rchk(OFS_ERR, 32'h0000_0000);
    rchk(OFS_ADDR_HI, 32'h0000_ffff);
    rchk(OFS_ADDR_LO, 32'hffff_ffff);
    apb(1'b1, 12'h0120, 32'hffff_ffff);
    check("unmapped", errBit, 1'b1);
    apb(1'b1, OFS_SEED, 32'h0000_1234);
    @(posedge clock);
    check("lfsr seed", backoffRand, 16'h1234);
    rchk(OFS_SEED, 32'h0000_1234);
  endtask : t_reset

  task automatic t_addr;
    apb(1'b1, OFS_ADDR_HI, 32'h0000_1122);
    apb(1'b1, OFS_ADDR_LO, 32'h3344_5566);
    // The low word lands at the edge that ends the transfer.
    @(posedge clock);
    check("station", stationAddr, 48'h1122_3344_5566);
  endtask : t_addr

  // Forced frame, slow partner; the bit must clear once sent.
  task automatic t_force;
    ackDelay <= 8'h28;
    apb(1'b1, OFS_PAUSE_CTL, 32'h8000_abcd);
    frame_chk(16'habcd);
    rchk(OFS_PAUSE_CTL, 32'h0000_abcd);
  endtask : t_force

  // High watermark sends quanta, low watermark then sends zero.
  task automatic t_auto;
    ackDelay <= 8'h00;
    pauseThresholdCfg.on <= 8'h04;
    pauseThresholdCfg.off <= 8'h02;
    apb(1'b1, OFS_PAUSE_CTL, 32'h4000_0055);
    rxFifoFill <= 16'h0800;
    frame_chk(16'h0055);
    rxFifoFill <= 16'h0400;
    frame_chk(16'h0000);
  endtask : t_auto

  task automatic t_honor;
    int n;
    apb(1'b1, OFS_PAUSE_CTL, 32'h2000_0000);
    @(posedge clock);
    rxPauseQuanta <= 16'h0002;
    rxPauseValid <= 1'b1;
    @(posedge clock);
    rxPauseValid <= 1'b0;
    n = 0;
    while (n < 1000) begin
      @(posedge clock);
      if (txHalt !== 1'b1) break;
      n++;
    end
    check("halt span", n, 2 * SLOT_CLKS);
    fullDuplex <= 1'b0;
    repeat (3) @(posedge clock);
    check("half duplex decode", ctlDecodeEn, 1'b0);
    fullDuplex <= 1'b1;
    apb(1'b1, OFS_PAUSE_CTL, 32'h1000_0000);
    // The decode enable trails the honour bit by one cycle.
    @(posedge clock);
    rxPauseValid <= 1'b1;
    @(posedge clock);
    rxPauseValid <= 1'b0;
    repeat (3) @(posedge clock);
    check("no decode", {ctlDecodeEn, txHalt}, 2'b00);
    check("pass", passPauseFrames, 1'b1);
  endtask : t_honor

  // Each event sets its own flag, which stays until written clear.
  task automatic t_errors;
    for (int i = 0; i < ERR_N; i++) begin
      @(posedge clock);
      errEvt <= 8'h01 << i;
      @(posedge clock);
      errEvt <= 8'h00;
      repeat (3) @(posedge clock);
      rchk(OFS_ERR, 32'h0000_0004 << i);
      apb(1'b1, OFS_ERR, 32'h0000_0004 << i);
      rchk(OFS_ERR, 32'h0000_0000);
    end
  endtask : t_errors

  task automatic t_usb;
    @(posedge clock);
    usbReset <= 1'b1;
    @(posedge clock);
    usbReset <= 1'b0;
    repeat (2) @(posedge clock);
    check("usb reset", stationAddr, 48'h1122_ffff_ffff);
  endtask : t_usb

  // Mid-run reset with an address source; a USB reset then restores it.
  task automatic t_src(input logic ee, input logic [47:0] exp);
    @(posedge clock);
    reset <= 1'b1;
    eepromPresent <= ee;
    otpConfigured <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    check("source load", stationAddr, exp);
    apb(1'b1, OFS_ADDR_LO, 32'h0000_0000);
    @(posedge clock);
    check("address write", stationAddr[31:0], 32'h0000_0000);
    usbReset <= 1'b1;
    @(posedge clock);
    usbReset <= 1'b0;
    repeat (2) @(posedge clock);
    check("usb restore", stationAddr, exp);
  endtask : t_src

  initial begin
    #500_000;
    error_cnt++;
    results();
  end

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, rxPauseValid, usbReset} = 5'b00000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fullDuplex = 1'b1;
    rxPauseQuanta = 16'h0000;
    rxFifoFill = 16'h0000;
    pauseThresholdCfg = 16'h0000;
    errEvt = 8'h00;
    ackDelay = 8'h00;
    eepromPresent = 1'b0;
    otpConfigured = 1'b0;
    eepromAddr = 48'ha1a2_a3a4_a5a6;
    otpAddr = 48'hb1b2_b3b4_b5b6;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_addr();
    t_force();
    t_auto();
    t_honor();
    t_errors();
    t_usb();
    t_src(1'b1, 48'ha1a2_a3a4_a5a6);
    t_src(1'b0, 48'hb1b2_b3b4_b5b6);
    results();
  end
endmodule : mac_pause_error_station_addr_tb
